// file: swm_regs.svh
// timing counts and constants for the single-wire bus master
`ifndef SWM_REGS_SVH
`define SWM_REGS_SVH
`define SWM_CLK_MHZ         50
// times in microseconds, as figures
`define SWM_RST_LOW_US      480
`define SWM_RST_HIGH_US     480
`define SWM_RST_MAX_US      960
`define SWM_PRES_SAMPLE_US  70
`define SWM_W1_LOW_US       6
`define SWM_W0_LOW_US       60
`define SWM_RD_LOW_US       2
`define SWM_RD_SAMPLE_US    13
`define SWM_RDV_US          15
`define SWM_SLOT_US         70
`define SWM_REC_US          5
`define SWM_PDLY_US         5
`define SWM_PROG_US         480
// derived cycle counts
`define SWM_RST_LOW_CYC     (`SWM_RST_LOW_US * `SWM_CLK_MHZ)
`define SWM_RST_HIGH_CYC    (`SWM_RST_HIGH_US * `SWM_CLK_MHZ)
`define SWM_RST_MAX_CYC     (`SWM_RST_MAX_US * `SWM_CLK_MHZ)
`define SWM_PRES_SAMPLE_CYC (`SWM_PRES_SAMPLE_US * `SWM_CLK_MHZ)
`define SWM_W1_LOW_CYC      (`SWM_W1_LOW_US * `SWM_CLK_MHZ)
`define SWM_W0_LOW_CYC      (`SWM_W0_LOW_US * `SWM_CLK_MHZ)
`define SWM_RD_LOW_CYC      (`SWM_RD_LOW_US * `SWM_CLK_MHZ)
`define SWM_RD_SAMPLE_CYC   (`SWM_RD_SAMPLE_US * `SWM_CLK_MHZ)
`define SWM_RDV_CYC         (`SWM_RDV_US * `SWM_CLK_MHZ)
`define SWM_SLOT_CYC        (`SWM_SLOT_US * `SWM_CLK_MHZ)
`define SWM_REC_CYC         (`SWM_REC_US * `SWM_CLK_MHZ)
`define SWM_PDLY_CYC        (`SWM_PDLY_US * `SWM_CLK_MHZ)
`define SWM_PROG_CYC        (`SWM_PROG_US * `SWM_CLK_MHZ)
// crc constants, reflected form, then rx fifo depth and width
`define SWM_CRC8_POLY       8'h8c
`define SWM_CRC16_POLY      16'ha001
`define SWM_CRC16_RESIDUE   16'hb001
`define SWM_FIFO_DEPTH      8
`define SWM_FIFO_WIDTH      8
`endif

// file: swm_pkg.sv
// types and crc step functions for the single-wire bus master
`include "swm_regs.svh"
package swm_pkg;
  typedef enum logic [1:0] {
    OP_RESET = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ  = 2'b10,
    OP_PROG  = 2'b11
  } swm_op_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RESET = 2'b01,
    ST_SLOT  = 2'b10,
    ST_PROG  = 2'b11
  } swm_state_type;

  typedef struct packed {
    swm_op_type op;
    logic       single;
    logic [7:0] data;
  } swm_cmd_type;

  // one lsb-first step of the 8-bit identity crc
  function automatic logic [7:0] swm_crc8_step(input logic [7:0] c, input logic b);
    logic [7:0] s;
    s = {1'b0, c[7:1]};
    return (c[0] ^ b) ? (s ^ `SWM_CRC8_POLY) : s;
  endfunction

  // one lsb-first step of the 16-bit data crc
  function automatic logic [15:0] swm_crc16_step(input logic [15:0] c, input logic b);
    logic [15:0] s;
    s = {1'b0, c[15:1]};
    return (c[0] ^ b) ? (s ^ `SWM_CRC16_POLY) : s;
  endfunction
endpackage

// file: swm_fifo.sv
// small flop fifo with valid/ready on both sides
module swm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push_w;
  logic             pop_w;

  // honest full and empty from the fill count
  assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rd_r];
  assign push_w      = in_valid_i & in_ready_o;
  assign pop_w       = out_valid_o & out_ready_i;

  // storage, no reset needed on data
  always_ff @(posedge core_clk_i) begin
    if (push_w) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push_w) wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + AW'(1);
      if (pop_w)  rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(push_w) - (AW+1)'(pop_w);
    end
  end
endmodule // swm_fifo

// file: swm_master.sv
// bus master controller for the single-wire dual switch slave
`include "swm_regs.svh"
module swm_master import swm_pkg::*; #(
  parameter int RST_LOW_CYC  = `SWM_RST_LOW_CYC,
  parameter int RST_HIGH_CYC = `SWM_RST_HIGH_CYC,
  parameter int PROG_CYC     = `SWM_PROG_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        cmd_valid_i,
  input  wire swm_cmd_type cmd_i,
  output logic             cmd_ready_o,
  output logic             done_o,
  output logic             presence_o,
  output logic             prog_refused_o,
  output logic             rx_valid_o,
  input  wire logic        rx_ready_i,
  output logic [7:0]       rx_data_o,
  input  wire logic        crc_clr_i,
  input  wire logic        crc_load_i,
  input  wire logic [15:0] crc_load_val_i,
  output logic [7:0]       crc8_o,
  output logic [15:0]      crc16_o,
  output logic             crc16_ok_o,
  input  wire logic        line_i,
  output logic             line_o,
  output logic             line_oe_o,
  output logic             prog_en_o
);
  // cycle counts; reset low, reset high and program lengths are parameters so a bench can shorten them
  localparam logic [15:0] T_RST_LOW  = 16'(RST_LOW_CYC);
  localparam logic [15:0] T_RST_END  = 16'(RST_LOW_CYC + RST_HIGH_CYC);
  localparam logic [15:0] T_PRES     = 16'(RST_LOW_CYC + `SWM_PRES_SAMPLE_CYC);
  localparam logic [15:0] T_W1       = 16'(`SWM_W1_LOW_CYC);
  localparam logic [15:0] T_W0       = 16'(`SWM_W0_LOW_CYC);
  localparam logic [15:0] T_RD_LOW   = 16'(`SWM_RD_LOW_CYC);
  localparam logic [15:0] T_RD_SMP   = 16'(`SWM_RD_SAMPLE_CYC);
  localparam logic [15:0] T_RDV      = 16'(`SWM_RDV_CYC);
  localparam logic [15:0] T_SLOT_END = 16'(`SWM_SLOT_CYC + `SWM_REC_CYC);
  localparam logic [15:0] T_PDLY     = 16'(`SWM_PDLY_CYC);
  localparam logic [15:0] T_PROG_END = 16'(`SWM_PDLY_CYC + PROG_CYC);
  localparam logic [15:0] T_RST_MAX  = 16'(`SWM_RST_MAX_CYC);

  swm_state_type st_r;
  swm_state_type st_nxt;
  logic [15:0]   tmr_r;
  logic [15:0]   tmr_nxt;
  logic [7:0]    sh_r;
  logic [2:0]    bit_r;
  logic          rd_r;
  logic          single_r;
  logic          smp_r;
  logic [7:0]    crc8_r;
  logic [15:0]   crc16_r;
  logic          presence_r;
  logic          done_r;
  logic          refused_r;
  logic          sync1_r;
  logic          sync2_r;
  logic          sync3_r;
  logic          line_lvl_r;

  logic          idle_w;
  logic          take_w;
  logic          prog_bad_w;
  logic [15:0]   low_len_w;
  logic          slot_drive_w;
  logic          rst_drive_w;
  logic          smp_pt_w;
  logic          slot_end_w;
  logic          bit_w;
  logic          last_bit_w;
  logic [7:0]    rx_word_w;
  logic          push_w;
  logic          fifo_in_ready_w;
  logic          crc16_ok_w;

  // pin synchroniser: a change counts once stages two and three agree
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync1_r    <= 1'b1;
      sync2_r    <= 1'b1;
      sync3_r    <= 1'b1;
      line_lvl_r <= 1'b1;
    end else begin
      sync1_r <= line_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) line_lvl_r <= sync3_r;
    end
  end

  // command acceptance; holds off new commands while rx fifo is full
  assign idle_w      = (st_r == ST_IDLE);
  assign cmd_ready_o = idle_w & fifo_in_ready_w;
  assign take_w      = cmd_valid_i & cmd_ready_o;
  assign crc16_ok_w  = (crc16_r == `SWM_CRC16_RESIDUE);
  assign prog_bad_w  = take_w & (cmd_i.op == OP_PROG) & ~crc16_ok_w;

  // line drive: open drain, only ever pulls low
  assign low_len_w    = rd_r ? T_RD_LOW : (sh_r[0] ? T_W1 : T_W0);
  assign slot_drive_w = (st_r == ST_SLOT) && (tmr_r < low_len_w);
  assign rst_drive_w  = (st_r == ST_RESET) && (tmr_r < T_RST_LOW);
  assign line_o       = 1'b0;
  assign line_oe_o    = slot_drive_w | rst_drive_w;
  // 12 V enable, after a short settle delay, line released meanwhile
  assign prog_en_o    = (st_r == ST_PROG) && (tmr_r >= T_PDLY) && (tmr_r < T_PROG_END);

  // slot timing points; sample late but inside the valid window
  assign smp_pt_w   = (st_r == ST_SLOT) && rd_r && (tmr_r == T_RD_SMP);
  assign slot_end_w = (st_r == ST_SLOT) && (tmr_r == T_SLOT_END);
  assign bit_w      = rd_r ? smp_r : sh_r[0];
  assign last_bit_w = single_r | (bit_r == 3'h7);
  assign rx_word_w  = single_r ? {7'h00, bit_w} : {bit_w, sh_r[7:1]};
  assign push_w     = slot_end_w & last_bit_w & rd_r;

  // sequencer next state
  always_comb begin
    st_nxt  = st_r;
    tmr_nxt = tmr_r + 16'h0001;
    case (st_r)
      ST_IDLE: begin
        tmr_nxt = 16'h0000;
        if (take_w) begin
          case (cmd_i.op)
            OP_RESET: st_nxt = ST_RESET;
            OP_WRITE: st_nxt = ST_SLOT;
            OP_READ:  st_nxt = ST_SLOT;
            OP_PROG:  st_nxt = crc16_ok_w ? ST_PROG : ST_IDLE;
            default:  st_nxt = ST_IDLE;
          endcase
        end
      end
      ST_RESET: if (tmr_r == T_RST_END) st_nxt = ST_IDLE;
      ST_SLOT: begin
        if (slot_end_w) begin
          tmr_nxt = 16'h0000;
          if (last_bit_w) st_nxt = ST_IDLE;
        end
      end
      ST_PROG: if (tmr_r == T_PROG_END) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  // state and timer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r  <= ST_IDLE;
      tmr_r <= 16'h0000;
    end else begin
      st_r  <= st_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  // byte shifter, lsb goes out first
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sh_r     <= 8'h00;
      bit_r    <= 3'h0;
      rd_r     <= 1'b0;
      single_r <= 1'b0;
    end else if (take_w) begin
      sh_r     <= cmd_i.data;
      bit_r    <= 3'h0;
      rd_r     <= (cmd_i.op == OP_READ);
      single_r <= cmd_i.single;
    end else if (slot_end_w) begin
      sh_r  <= {bit_w, sh_r[7:1]};
      bit_r <= bit_r + 3'h1;
    end
  end

  // read sample and presence detect
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      smp_r      <= 1'b1;
      presence_r <= 1'b0;
    end else begin
      if (smp_pt_w) smp_r <= line_lvl_r;
      if ((st_r == ST_RESET) && (tmr_r == T_PRES)) presence_r <= ~line_lvl_r;
    end
  end

  // completion pulses
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      done_r    <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      done_r    <= ((st_r != ST_IDLE) && (st_nxt == ST_IDLE)) | prog_bad_w;
      refused_r <= prog_bad_w;
    end
  end

  // crc engines see every bit on the wire, so the user only checks the result;
  // nothing aborts a transfer on mismatch, only a program command is refused; the user decides what to repeat
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      crc8_r  <= 8'h00;
      crc16_r <= 16'h0000;
    end else if (crc_clr_i) begin
      crc8_r  <= 8'h00;
      crc16_r <= 16'h0000;
    end else if (crc_load_i) begin
      crc16_r <= crc_load_val_i;
    end else if (slot_end_w) begin
      crc8_r  <= swm_crc8_step(crc8_r, bit_w);
      crc16_r <= swm_crc16_step(crc16_r, bit_w);
    end
  end

  assign done_o         = done_r;
  assign presence_o     = presence_r;
  assign prog_refused_o = refused_r;
  assign crc8_o         = crc8_r;
  assign crc16_o        = crc16_r;
  assign crc16_ok_o     = crc16_ok_w;

  // read bytes queue here; a full queue holds off new commands
  swm_fifo #(
    .WIDTH(`SWM_FIFO_WIDTH),
    .DEPTH(`SWM_FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .in_valid_i (push_w),
    .in_ready_o (fifo_in_ready_w),
    .in_data_i  (rx_word_w),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o (rx_data_o)
  );

  // checks on the driven pins and sequencing
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // named steps of a reset and of a slot opening
  sequence s_take_reset;
    take_w && (cmd_i.op == OP_RESET);
  endsequence
  sequence s_low_held;
    line_oe_o [*8];
  endsequence
  sequence s_take_slot;
    take_w && ((cmd_i.op == OP_READ) || (cmd_i.op == OP_WRITE));
  endsequence

  a_reset_low_start: assert property (s_take_reset |=> s_low_held)
    else $error("reset pulse not driven low at start");
  a_reset_low_len: assert property ((st_r == ST_RESET) && (tmr_r == T_RST_LOW - 16'h0001)
    |-> line_oe_o ##1 !line_oe_o)
    else $error("reset low length wrong");
  a_reset_max: assert property ((st_r == ST_RESET) && line_oe_o |-> tmr_r < T_RST_MAX)
    else $error("reset low exceeds limit");
  a_slot_edge: assert property (s_take_slot |=> line_oe_o && (tmr_r == 16'h0000))
    else $error("slot did not open with low edge");
  a_write1_release: assert property ((st_r == ST_SLOT) && !rd_r && sh_r[0]
    && (tmr_r >= T_W1) |-> !line_oe_o)
    else $error("write one held low too long");
  // presence is listened for with the line released
  a_presence_free: assert property ((st_r == ST_RESET) && (tmr_r == T_PRES) |-> !line_oe_o)
    else $error("line pulled low at presence sample");
  a_read_window: assert property (smp_pt_w |-> (tmr_r < T_RDV) && (tmr_r > T_RD_LOW))
    else $error("read sample outside valid window");
  a_prog_crc: assert property ($rose(prog_en_o) |-> crc16_ok_w && $past(crc16_ok_w))
    else $error("program pulse without crc check");
  a_prog_release: assert property (prog_en_o |-> !line_oe_o)
    else $error("line pulled low while programming");
  a_prog_refuse: assert property (prog_bad_w |=> refused_r && done_r && (st_r == ST_IDLE))
    else $error("bad crc program not refused");
  a_crc_step: assert property (slot_end_w && !crc_clr_i && !crc_load_i
    |=> crc16_r == swm_crc16_step($past(crc16_r), $past(bit_w)))
    else $error("crc not advanced by one bit");
endmodule // swm_master

// file: swm_slave_model.sv
// behavioural slave device on the single-wire line, seen from its data pin
module swm_slave_model #(
  parameter int RST_MIN_NS = 75000,
  parameter int PDH_NS     = 30000,
  parameter int PDL_NS     = 60000,
  parameter int WSMP_NS    = 30000,
  parameter int RHOLD_NS   = 15000,
  parameter int SINGLE_CH  = 0
) (
  input  wire logic       line_i,
  input  wire logic       present_i,
  input  wire logic       tx_en_i,
  input  wire logic [7:0] tx_bits_i,
  input  wire logic       switch_pin_a_i,
  input  wire logic       switch_pin_b_i,
  output logic            pull_o,
  output logic [7:0]      rx_byte_o,
  output logic            qual_o,
  output logic [15:0]     crc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  time  t0;
  int   idx;
  logic smp;
  logic [4:0] sel;
  logic [1:0] act;
  logic [1:0] pins;
  int   nrx;

  // search qualifier from the five select bits; f is the channel flip-flops
  function automatic logic qualify(input logic [4:0] s, input logic [1:0] l,
                                   input logic [1:0] f, input logic [1:0] p);
    logic [1:0] v;
    v = (s[2:1] == 2'b01) ? l : ((s[2:1] == 2'b10) ? f : p);
    if (SINGLE_CH != 0) v[1] = 1'b0;
    if (s[2:1] == 2'b00) return ~s[0];
    if (s[4:3] == 2'b00) return ~s[0];
    return ((v[0] & s[3]) | (v[1] & s[4])) == s[0];
  endfunction

  // activity latches; waits a moment so the first pin values are not an edge
  initial begin
    act = 2'b00;
    #1;
    pins = {switch_pin_b_i, switch_pin_a_i};
    forever begin
      @(switch_pin_a_i or switch_pin_b_i);
      act = act | (pins ^ {switch_pin_b_i, switch_pin_a_i});
      pins = {switch_pin_b_i, switch_pin_a_i};
    end
  end

  // every slot starts at a falling edge; own pulls never start a slot
  initial begin
    pull_o = 1'b0;
    rx_byte_o = 8'h00;
    qual_o = 1'b0;
    crc_o = 16'h0000;
    nrx = 0;
    // no status write is modelled, so the power-on selection stands
    sel = 5'h1f;
    idx = 0;
    forever begin
      @(negedge line_i);
      t0 = $time;
      if (tx_en_i) begin
        if (tx_bits_i[idx] == 1'b0) begin
          pull_o = 1'b1;
          #(RHOLD_NS);
          pull_o = 1'b0;
        end
        idx = (idx + 1) % 8;
      end else begin
        #(WSMP_NS);
        smp = line_i;
        wait (line_i);
        // a long low is a reset, so the sampled bit is thrown away
        if ($time - t0 >= RST_MIN_NS) begin
          idx = 0;
          nrx = 0;
          crc_o = 16'h0000;
          if (present_i) begin
            #(PDH_NS);
            pull_o = 1'b1;
            #(PDL_NS);
            pull_o = 1'b0;
          end
        end else begin
          rx_byte_o = {smp, rx_byte_o[7:1]};
          crc_o = (crc_o[0] ^ smp) ? ((crc_o >> 1) ^ 16'ha001) : (crc_o >> 1);
          nrx = nrx + 1;
          // the source is sampled once the whole search command byte is in
          if ((nrx % 8 == 0) && (rx_byte_o == 8'hec)) begin
            qual_o = qualify(sel, act, 2'b11, {switch_pin_b_i, switch_pin_a_i});
          end
        end
      end
    end
  end
endmodule // swm_slave_model

// file: tb_swm_master.sv
// self-checking bench for the single-wire bus master
module tb_swm_master import swm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // shortened reset, still long enough for the model to tell it from a slot
  localparam int RST_LOW  = 3200;
  localparam int RST_HIGH = 3800;
  localparam int PROG     = 50;
  localparam int SLOT     = 3751;
  logic        core_clk_i, rst_i, cmd_valid_i, rx_ready_i, crc_clr_i, crc_load_i;
  swm_cmd_type cmd_i;
  logic [15:0] crc_load_val_i, crc16_o, e16;
  logic [7:0]  rx_data_o, crc8_o, rx_byte, tx_bits, e8;
  logic        cmd_ready_o, done_o, presence_o, prog_refused_o, rx_valid_o;
  logic        crc16_ok_o, line_o, line_oe_o, prog_en_o, pull, present, tx_en, rf;
  logic        line_w;
  logic        sw_a, sw_b, qual;
  logic [15:0] crc_s;
  int          failures, n_tests, n, np, no;

  // open-drain wire with pull-up: low if either side pulls
  assign line_w = (line_oe_o ? line_o : 1'b1) & ~pull;

  swm_master #(.RST_LOW_CYC(RST_LOW), .RST_HIGH_CYC(RST_HIGH), .PROG_CYC(PROG)) DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .presence_o(presence_o),
    .prog_refused_o(prog_refused_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
    .rx_data_o(rx_data_o), .crc_clr_i(crc_clr_i), .crc_load_i(crc_load_i),
    .crc_load_val_i(crc_load_val_i), .crc8_o(crc8_o), .crc16_o(crc16_o),
    .crc16_ok_o(crc16_ok_o), .line_i(line_w), .line_o(line_o), .line_oe_o(line_oe_o),
    .prog_en_o(prog_en_o));

  // reset limit sits between the longest slot low and the bench reset low
  swm_slave_model #(.RST_MIN_NS(62000), .PDH_NS(15000)) slave (
    .line_i(line_w), .present_i(present), .tx_en_i(tx_en), .tx_bits_i(tx_bits),
    .switch_pin_a_i(sw_a), .switch_pin_b_i(sw_b), .qual_o(qual), .crc_o(crc_s),
    .pull_o(pull), .rx_byte_o(rx_byte));

  // reflected lsb-first crc, own code so the engine is not checked against itself
  function automatic logic [15:0] ref_crc(input logic [15:0] c, input logic [7:0] d,
                                          input logic [15:0] p);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ p) : (c >> 1);
    end
    return c;
  endfunction

  task automatic conclude();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // compare tasks, one per kind of result
  task automatic chk_b(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  // cycle counts allow two cycles either way for synchroniser and edge alignment
  task automatic chk_n(input int got, input int exp);
    n_tests++;
    if (got < exp - 2 || got > exp + 2) begin
      failures++;
      $display("Error at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic tick(inout int k, input int lim);
    @(negedge core_clk_i);
    k++;
    if (k > lim) begin
      failures++;
      $display("Error at %0t: wait ran out", $time);
      conclude();
    end
  endtask

  // one command: held until taken, then counts busy, low-line and program cycles
  task automatic run(input swm_op_type op, input logic single, input logic [7:0] d);
    int w;
    @(negedge core_clk_i);
    cmd_i = '{op: op, single: single, data: d};
    cmd_valid_i = 1'b1;
    w = 0;
    while (cmd_ready_o !== 1'b1) tick(w, 100);
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    n = 1;
    np = 0;
    no = 0;
    while (done_o !== 1'b1) begin
      if (prog_en_o === 1'b1) np++;
      if (line_oe_o === 1'b1) no++;
      tick(n, 40000);
    end
    rf = prog_refused_o;
  endtask

  task automatic crc_ctl(input logic clr, input logic ld, input logic [15:0] v);
    @(negedge core_clk_i);
    crc_clr_i = clr;
    crc_load_i = ld;
    crc_load_val_i = v;
    @(negedge core_clk_i);
    crc_clr_i = 1'b0;
    crc_load_i = 1'b0;
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  initial begin
    rst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    rx_ready_i = 1'b0;
    crc_clr_i = 1'b0;
    crc_load_i = 1'b0;
    crc_load_val_i = 16'h0000;
    present = 1'b1;
    tx_en = 1'b0;
    tx_bits = 8'h5a;
    sw_a = 1'b1;
    sw_b = 1'b0;
    failures = 0;
    n_tests = 0;
    repeat (8) @(negedge core_clk_i);
    rst_i = 1'b0;
    chk_b(line_oe_o, 1'b0);
    chk_b(cmd_ready_o, 1'b1);
    chk_b(presence_o, 1'b0);
    chk_b(line_o, 1'b0);
    // an edge on pin b sets only that channel's latch
    sw_b = 1'b1;
    @(negedge core_clk_i);
    sw_b = 1'b0;
    chk_b(slave.act[1], 1'b1);
    chk_b(slave.act[0], 1'b0);
    // reset sequence answered by the device
    run(OP_RESET, 1'b0, 8'h00);
    chk_b(presence_o, 1'b1);
    chk_n(no, RST_LOW);
    chk_n(n, RST_LOW + RST_HIGH + 2);
    // cleared engine gives no residue, so the program pulse is refused
    crc_ctl(1'b1, 1'b0, 16'h0000);
    chk16(crc16_o, 16'h0000);
    chk8(crc8_o, 8'h00);
    run(OP_PROG, 1'b0, 8'h00);
    chk_b(rf, 1'b1);
    chk_n(np, 0);
    // the sequence carries on after the refusal with a command byte
    run(OP_WRITE, 1'b0, 8'hec);
    chk8(rx_byte, 8'hec);
    chk_n(no, 5 * 300 + 3 * 3000);
    chk_n(n, 8 * SLOT + 1);
    e16 = ref_crc(16'h0000, 8'hec, 16'h008c);
    e8 = e16[7:0];
    chk8(crc8_o, e8);
    chk16(crc16_o, ref_crc(16'h0000, 8'hec, 16'ha001));
    // power-on selection: both channels, pin level, polarity one; pin a is high
    chk_b(qual, 1'b1);
    chk16(crc_s, ref_crc(16'h0000, 8'hec, 16'ha001));
    // seven single-bit reads and one byte read, consumer stalled until the fifo refuses
    tx_en = 1'b1;
    for (int i = 0; i < 7; i++) begin
      run(OP_READ, 1'b1, 8'h00);
      chk_n(no, 100);
    end
    run(OP_READ, 1'b0, 8'h00);
    chk_n(no, 8 * 100);
    chk_n(n, 8 * SLOT + 1);
    chk_b(cmd_ready_o, 1'b0);
    tx_en = 1'b0;
    for (int i = 0; i < 8; i++) begin
      chk_b(rx_valid_o, 1'b1);
      // the byte read starts at the device's eighth bit and wraps round
      e8 = (i < 7) ? {7'h00, tx_bits[i]} : {tx_bits[6:0], tx_bits[7]};
      chk8(rx_data_o, e8);
      rx_ready_i = 1'b1;
      @(negedge core_clk_i);
      rx_ready_i = 1'b0;
    end
    chk_b(rx_valid_o, 1'b0);
    chk_b(cmd_ready_o, 1'b1);
    // a loaded residue stands for a confirmed crc and permits programming
    crc_ctl(1'b0, 1'b1, 16'hb001);
    chk16(crc16_o, 16'hb001);
    chk_b(crc16_ok_o, 1'b1);
    run(OP_PROG, 1'b0, 8'h00);
    chk_b(rf, 1'b0);
    chk_n(np, PROG);
    chk_n(no, 0);
    chk_n(n, PROG + 252);
    // second reset with nobody on the line
    present = 1'b0;
    run(OP_RESET, 1'b0, 8'h00);
    chk_b(presence_o, 1'b0);
    chk_n(no, RST_LOW);
    conclude();
  end
endmodule // tb_swm_master
